// File: swmg_board.sv
`default_nettype none

// board side of the pins: a pin the device leaves floating shows the board's
// own level, never the device's last drive, so a stale latch cannot hide
module swmg_board import swmg_pkg::*; (
    // device drive
    input wire swmg_pkg::swmg_pin_drive_t pin_drive,
    // board level and resolved pin
    input wire swmg_pkg::swmg_pins_t board_level,
    output swmg_pkg::swmg_pins_t pin_in
);
    // each pin carries the device level only while its enable is low
    assign pin_in = (pin_drive.level & ~pin_drive.oe_n) | (board_level & pin_drive.oe_n);
endmodule

`default_nettype wire

// File: swmg_checker.sv
`default_nettype none
`include "swmg_consts.svh"

module swmg_checker import swmg_pkg::*; #(
    parameter int LOSS_LIMIT = `SWMG_LOSS_LIMIT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    // pins
    input wire swmg_pkg::swmg_pins_t pin_in,
    input wire swmg_pkg::swmg_pin_drive_t pin_drive,
    input wire swmg_pkg::swmg_pin_drive_t alt_drive,
    input wire swmg_pkg::swmg_pins_t alt_pin_level,
    // events and interrupt
    input wire swmg_pkg::swmg_evt_t evt,
    input wire logic arb_abort,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] up;
    logic [7:0] losses;
    logic [7:0] next_losses;
    wire logic wr = psel && penable && pwrite;
    // shadow loss count; a win or an abort starts it again
    assign next_losses = evt.arb_won ? 8'h00 : !evt.arb_lost ? losses :
        (losses == 8'(LOSS_LIMIT - 1)) ? 8'h00 : losses + 8'h01;
    // up guards the synchroniser, which holds reset values for two edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 2'h0;
            losses <= 8'h00;
        end else begin
            up <= (up == 2'h3) ? up : up + 2'h1;
            losses <= next_losses;
        end
    end
    chk_abort_on_limit: assert property (
        evt.arb_lost && !evt.arb_won && losses == 8'(LOSS_LIMIT - 1) |-> ##[1:2] arb_abort)
        else $error("abort missing after loss limit");
    chk_abort_cause: assert property (
        arb_abort |-> $past(evt.arb_lost) || $past(evt.arb_lost, 2))
        else $error("abort without a loss");
    chk_abort_single: assert property (arb_abort |=> !arb_abort)
        else $error("abort longer than one cycle");
    chk_pin_level_sync: assert property (
        up == 2'h3 |-> alt_pin_level == $past(pin_in, 2))
        else $error("pin level not two cycles behind pin");
    chk_drive_cause: assert property (
        $changed(pin_drive) |-> $changed(alt_drive) || $past(wr))
        else $error("pin drive changed with no cause");
    chk_irq_rise: assert property ($rose(irq) |-> $past(evt != '0) || $past(wr))
        else $error("irq rose with no event");
    chk_irq_fall: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell with no write");
    chk_slverr_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    cover property (arb_abort);
    cover property (irq);
    cover property (pslverr);
endmodule

bind swmg_regs swmg_checker #(.LOSS_LIMIT(LOSS_LIMIT)) u_swmg_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pslverr(pslverr), .pin_in(pin_in), .pin_drive(pin_drive), .alt_drive(alt_drive),
    .alt_pin_level(alt_pin_level), .evt(evt), .arb_abort(arb_abort), .irq(irq));

`default_nettype wire

// File: swmg_consts.svh
`ifndef SWMG_CONSTS_SVH
`define SWMG_CONSTS_SVH

// bus geometry
`define SWMG_ADDR_W 12
`define SWMG_PIN_COUNT 16

// register byte offsets
`define SWMG_OFF_SCRATCH 12'h0334
`define SWMG_OFF_FUNC 12'h0338
`define SWMG_OFF_DIR 12'h033C
`define SWMG_OFF_DATA 12'h0340
`define SWMG_OFF_STATUS 12'h0344
`define SWMG_OFF_IRQ_STATUS 12'h0380
`define SWMG_OFF_IRQ_ENABLE 12'h0384
`define SWMG_OFF_IRQ_CLEAR 12'h0388

// reset values
`define SWMG_RST_WORD 32'h0000_0000
`define SWMG_RST_PINS 16'h0000
`define SWMG_RST_ADDR7 7'h00

// implemented bits of the pin registers
`define SWMG_PIN_MASK 32'h0000_FFFF

// status register field positions
`define SWMG_SLV_ADDR_LSB 1
`define SWMG_SLV_ADDR_MSB 7
`define SWMG_MST_ADDR_LSB 9
`define SWMG_MST_ADDR_MSB 15
`define SWMG_BIT_LOAD_DONE 24
`define SWMG_BIT_NACK 25
`define SWMG_BIT_LOST_ARB 26
`define SWMG_BIT_MISPLACED 27
`define SWMG_BIT_CHECKSUM 28
`define SWMG_BIT_UNMAPPED 29

// write-one-to-clear bits of the status word, and all event bits
`define SWMG_W1C_MASK 32'h3E00_0000
`define SWMG_EVT_MASK 32'h3F00_0000

// consecutive arbitration losses before the transaction is given up
`define SWMG_LOSS_LIMIT 16

// cycles from reset release to strap capture (after the two-stage sync)
`define SWMG_STRAP_CAPTURE 2'h2

`endif

// File: swmg_pkg.sv
`default_nettype none
`include "swmg_consts.svh"

package swmg_pkg;

    typedef logic [`SWMG_PIN_COUNT-1:0] swmg_pins_t;

    // drive of a pin group: level plus active-low output enable
    typedef struct packed {
        swmg_pins_t level;
        swmg_pins_t oe_n;
    } swmg_pin_drive_t;

    // one-cycle event pulses from the management bus master and loader
    typedef struct packed {
        logic load_done;
        logic nack;
        logic arb_lost;
        logic arb_won;
        logic misplaced;
        logic checksum_bad;
        logic unmapped_target;
    } swmg_evt_t;

    // hardware-initialised bus addresses, as strap pins
    typedef struct packed {
        logic [6:0] slave_addr;
        logic [6:0] master_addr;
    } swmg_strap_t;

endpackage

`default_nettype wire

// File: swmg_regs.sv
// The implementer's own choice: register access over APB.
`default_nettype none
`include "swmg_consts.svh"

module swmg_regs #(
    parameter int LOSS_LIMIT = `SWMG_LOSS_LIMIT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SWMG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,

    // general purpose pins
    input wire swmg_pkg::swmg_pins_t pin_in,
    output swmg_pkg::swmg_pin_drive_t pin_drive,

    // alternate function logic, same clock
    input wire swmg_pkg::swmg_pin_drive_t alt_drive,
    output swmg_pkg::swmg_pins_t alt_pin_level,

    // initialisation straps, from pins
    input wire swmg_pkg::swmg_strap_t strap_in,

    // management bus master and serial loader events
    input wire swmg_pkg::swmg_evt_t evt,
    output logic arb_abort,

    // interrupt
    output logic irq
);
    import swmg_pkg::*;

    localparam int LOSS_W = $clog2(LOSS_LIMIT + 1);

    // byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = `SWMG_RST_WORD;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // masked merge of written data into a register
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                          input logic [31:0] m);
        return (cur & ~m) | (wd & m);
    endfunction

    // sticky flag update: a set in the clearing cycle wins
    function automatic logic [31:0] sticky_next(input logic [31:0] cur,
                                                input logic [31:0] set,
                                                input logic [31:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // two-stage synchronisers for everything that comes from pins
    swmg_pins_t pin_meta;
    swmg_pins_t pin_sync;
    swmg_strap_t strap_meta;
    swmg_strap_t strap_sync;

    // register state
    logic [31:0] scratch;
    logic [31:0] func_sel;
    logic [31:0] dir_cfg;
    swmg_pins_t out_latch;
    logic [6:0] slave_addr;
    logic [6:0] master_addr;
    logic [1:0] strap_cnt;
    logic [31:0] sts_flags;
    logic [31:0] irq_sts;
    logic [31:0] irq_en;
    logic [LOSS_W-1:0] loss_cnt;
    logic err_q;

    // bus phase decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_acc = access_ph & pwrite;
    wire [31:0] wmask = strb_mask(pstrb);

    // address decode; misaligned addresses fall through to the error answer
    wire hit_scratch = (paddr == `SWMG_OFF_SCRATCH);
    wire hit_func = (paddr == `SWMG_OFF_FUNC);
    wire hit_dir = (paddr == `SWMG_OFF_DIR);
    wire hit_data = (paddr == `SWMG_OFF_DATA);
    wire hit_status = (paddr == `SWMG_OFF_STATUS);
    wire hit_irq_sts = (paddr == `SWMG_OFF_IRQ_STATUS);
    wire hit_irq_en = (paddr == `SWMG_OFF_IRQ_ENABLE);
    wire hit_irq_clr = (paddr == `SWMG_OFF_IRQ_CLEAR);
    wire hit_any = hit_scratch | hit_func | hit_dir | hit_data | hit_status |
                   hit_irq_sts | hit_irq_en | hit_irq_clr;

    // pin mode decode
    wire [31:0] pin_wmask = wmask & `SWMG_PIN_MASK;
    wire [`SWMG_PIN_COUNT-1:0] alt_mode = func_sel[`SWMG_PIN_COUNT-1:0];
    wire [`SWMG_PIN_COUNT-1:0] gp_out_mode = ~alt_mode & dir_cfg[`SWMG_PIN_COUNT-1:0];
    wire [`SWMG_PIN_COUNT-1:0] data_wmask = pin_wmask[`SWMG_PIN_COUNT-1:0] & gp_out_mode;

    // status word as software sees it
    wire [31:0] status_word = sts_flags |
        {16'h0000, master_addr, 1'b0, slave_addr, 1'b0};

    // read mux; the clear register reads as zero
    wire [31:0] rd_data =
        hit_scratch ? scratch :
        hit_func ? func_sel :
        hit_dir ? dir_cfg :
        hit_data ? {16'h0000, pin_sync} :
        hit_status ? status_word :
        hit_irq_sts ? irq_sts :
        hit_irq_en ? irq_en :
        `SWMG_RST_WORD;

    // arbitration loss counting
    wire loss_limit_hit = evt.arb_lost & (loss_cnt == LOSS_W'(LOSS_LIMIT - 1));

    // event vector in the status layout
    wire [31:0] evt_set =
        ({31'h0000_0000, evt.load_done | evt.checksum_bad} << `SWMG_BIT_LOAD_DONE) |
        ({31'h0000_0000, evt.nack} << `SWMG_BIT_NACK) |
        ({31'h0000_0000, loss_limit_hit} << `SWMG_BIT_LOST_ARB) |
        ({31'h0000_0000, evt.misplaced} << `SWMG_BIT_MISPLACED) |
        ({31'h0000_0000, evt.checksum_bad} << `SWMG_BIT_CHECKSUM) |
        ({31'h0000_0000, evt.unmapped_target} << `SWMG_BIT_UNMAPPED);

    // write-one-to-clear vectors
    wire [31:0] sts_clr = (wr_acc & hit_status) ? (pwdata & wmask & `SWMG_W1C_MASK) :
                          `SWMG_RST_WORD;
    wire [31:0] irq_clr = (wr_acc & hit_irq_clr) ? (pwdata & wmask & `SWMG_EVT_MASK) :
                          `SWMG_RST_WORD;

    // apb answers: one access cycle, data registered in the setup cycle
    assign pready = access_ph;
    assign pslverr = access_ph & err_q;

    // pin drive; alternate mode hands the pin over completely
    assign pin_drive.level = (alt_mode & alt_drive.level) | (~alt_mode & out_latch);
    assign pin_drive.oe_n = (alt_mode & alt_drive.oe_n) |
                            (~alt_mode & ~dir_cfg[`SWMG_PIN_COUNT-1:0]);
    assign alt_pin_level = pin_sync;

    // the interrupt follows enabled sticky bits, no extra latency
    assign irq = |(irq_sts & irq_en);

    // pin synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= `SWMG_RST_PINS;
            pin_sync <= `SWMG_RST_PINS;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // strap synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= strap_in;
            strap_sync <= strap_meta;
        end
    end

    // straps are taken once, after the synchroniser has filled since release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt <= 2'h0;
        end else if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
        end
    end

    // hardware-initialised addresses, read-only afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_addr <= `SWMG_RST_ADDR7;
            master_addr <= `SWMG_RST_ADDR7;
        end else if (strap_cnt == `SWMG_STRAP_CAPTURE) begin
            slave_addr <= strap_sync.slave_addr;
            master_addr <= strap_sync.master_addr;
        end
    end

    // read data and error are prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SWMG_RST_WORD;
            err_q <= 1'b0;
        end else if (setup_ph) begin
            prdata <= pwrite ? `SWMG_RST_WORD : rd_data;
            err_q <= ~hit_any;
        end
    end

    // scratch word, no side effects anywhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch <= `SWMG_RST_WORD;
        end else if (wr_acc & hit_scratch) begin
            scratch <= merge(scratch, pwdata, wmask);
        end
    end

    // function select and direction; upper bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_sel <= `SWMG_RST_WORD;
            dir_cfg <= `SWMG_RST_WORD;
        end else begin
            if (wr_acc & hit_func) begin
                func_sel <= merge(func_sel, pwdata, pin_wmask);
            end
            if (wr_acc & hit_dir) begin
                dir_cfg <= merge(dir_cfg, pwdata, pin_wmask);
            end
        end
    end

    // output latch: pins not in plain output mode ignore the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch <= `SWMG_RST_PINS;
        end else if (wr_acc & hit_data) begin
            out_latch <= (out_latch & ~data_wmask) | (pwdata[15:0] & data_wmask);
        end
    end

    // consecutive losses; a win or the abort starts the count again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_cnt <= '0;
            arb_abort <= 1'b0;
        end else begin
            arb_abort <= loss_limit_hit;
            if (evt.arb_won || loss_limit_hit) begin
                loss_cnt <= '0;
            end else if (evt.arb_lost) begin
                loss_cnt <= loss_cnt + LOSS_W'(1);
            end
        end
    end

    // status flags; done bit is read-only so its clear term is masked off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_flags <= `SWMG_RST_WORD;
        end else begin
            sts_flags <= sticky_next(sts_flags, evt_set, sts_clr);
        end
    end

    // interrupt status and enable share the event layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts <= `SWMG_RST_WORD;
            irq_en <= `SWMG_RST_WORD;
        end else begin
            irq_sts <= sticky_next(irq_sts, evt_set, irq_clr);
            if (wr_acc & hit_irq_en) begin
                irq_en <= merge(irq_en, pwdata, wmask & `SWMG_EVT_MASK);
            end
        end
    end

endmodule

`default_nettype wire

// File: test_switch_misc_gpio_status_regs.sv
`default_nettype none
`include "swmg_consts.svh"

module test_switch_misc_gpio_status_regs import swmg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ST = {16'h0000, 7'h51, 1'b0, 7'h2B, 1'b0};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, arb_abort, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    swmg_pins_t pin_in, alt_lvl, board = 16'h5A5A;
    swmg_pin_drive_t pin_drive, alt = {16'h0002, 16'hFFFE};
    swmg_evt_t evt = '0;
    swmg_strap_t strap = {7'h2B, 7'h51};
    logic [6:0] evs [5] = '{7'h40, 7'h20, 7'h04, 7'h02, 7'h01};
    int n_fail = 0, compares = 0;

    always #10 pclk = ~pclk;

    swmg_regs #(.LOSS_LIMIT(4)) u_swmg_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
        .pin_drive(pin_drive), .alt_drive(alt), .alt_pin_level(alt_lvl), .strap_in(strap),
        .evt(evt), .arb_abort(arb_abort), .irq(irq));
    swmg_board u_swmg_board (.pin_drive(pin_drive), .board_level(board), .pin_in(pin_in));

    task automatic conclude();
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask

    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // events are single-cycle pulses with an idle cycle between them
    task automatic pulse(input logic [6:0] v, input int n);
        repeat (n) begin
            evt <= v;
            @(posedge pclk);
            evt <= '0;
            @(posedge pclk);
        end
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SWMG_OFF_SCRATCH, 32'h0000_0000);
        check("scratch reset", rd, 32'h0000_0000);
        apb(1'b0, `SWMG_OFF_FUNC, 32'h0000_0000);
        check("func reset", rd, 32'h0000_0000);
        apb(1'b0, `SWMG_OFF_DIR, 32'h0000_0000);
        check("dir reset", rd, 32'h0000_0000);
        apb(1'b0, `SWMG_OFF_STATUS, 32'h0000_0000);
        check("status reset", rd, ST);
        apb(1'b1, `SWMG_OFF_SCRATCH, 32'hA5A5_5A5A);
        apb(1'b0, `SWMG_OFF_SCRATCH, 32'h0000_0000);
        check("scratch", rd, 32'hA5A5_5A5A);
        // pins 1:0 alternate, 3:0 outputs: only 3:2 follow the data latch
        apb(1'b1, `SWMG_OFF_FUNC, 32'hFFFF_0003);
        apb(1'b1, `SWMG_OFF_DIR, 32'hFFFF_000F);
        apb(1'b1, `SWMG_OFF_DATA, 32'h0000_FFFF);
        apb(1'b0, `SWMG_OFF_FUNC, 32'h0000_0000);
        check("func reserved", rd, 32'h0000_0003);
        check("enables", 32'(pin_drive.oe_n), 32'h0000_FFF2);
        check("levels", 32'(pin_drive.level & ~pin_drive.oe_n), 32'h0000_000C);
        apb(1'b0, `SWMG_OFF_DATA, 32'h0000_0000);
        check("pin data", rd, 32'h0000_5A5E);
        // ones on input pin 4 must not reach the latch before it turns output
        apb(1'b1, `SWMG_OFF_DATA, 32'h0000_FFF3);
        apb(1'b1, `SWMG_OFF_DIR, 32'h0000_001F);
        check("new output", 32'(pin_drive.oe_n), 32'h0000_FFE2);
        check("latch kept", 32'(pin_drive.level & ~pin_drive.oe_n), 32'h0000_0000);
        apb(1'b0, 12'h300, 32'h0000_0000);
        check("unmapped", {rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, `SWMG_OFF_IRQ_ENABLE, 32'h3F00_0000);
        foreach (evs[i]) pulse(evs[i], 1);
        pulse(7'h10, 3);
        pulse(7'h08, 1);
        apb(1'b0, `SWMG_OFF_STATUS, 32'h0000_0000);
        check("events", rd, ST | 32'h3B00_0000);
        // the win above restarted the count, so three more losses stay short
        pulse(7'h10, 3);
        apb(1'b0, `SWMG_OFF_STATUS, 32'h0000_0000);
        check("loss count", rd, ST | 32'h3B00_0000);
        pulse(7'h10, 1);
        check("abort pulse", 32'(arb_abort), 32'h0000_0001);
        apb(1'b0, `SWMG_OFF_STATUS, 32'h0000_0000);
        check("lost arb", rd, ST | 32'h3F00_0000);
        apb(1'b1, `SWMG_OFF_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `SWMG_OFF_STATUS, 32'h0000_0000);
        check("status clear", rd, ST | 32'h0100_0000);
        check("irq set", 32'(irq), 32'h0000_0001);
        apb(1'b1, `SWMG_OFF_IRQ_ENABLE, 32'h0000_0000);
        check("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, `SWMG_OFF_IRQ_ENABLE, 32'h3F00_0000);
        apb(1'b1, `SWMG_OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
        apb(1'b0, `SWMG_OFF_IRQ_STATUS, 32'h0000_0000);
        check("irq clear", {rd[31:1], irq}, 32'h0000_0000);
        conclude();
    end
endmodule

`default_nettype wire
